// ===== verilog/pcl_cfg_lock.sv
// Peripheral enable register with key lock, plus read-only device strap status.
// Assumes a single-cycle strobe register master on mclk and strap pins from outside.
//
// Overview of operation
// - Lock read: status bit 0, upper bits zero
// - Resets locked; locked writes leave enables unchanged
// - Enable register reads ignore the lock
// - Full 32-bit key clears the lock
// - Every enable register write relocks
// - Read after write returns the applied value
// - Strap status read-only, reserved bits zero
// - Bit 11: network MAC enable strap
// - Bit 10: host port width strap
// - Bits 6:5: CPU clock multiplier strap
// - Bit 4: byte order, little-endian default
// - Bits 3:2: boot mode strap
// - Bits 1:0: external memory clock source
// - Strap pins latched only at reset
// - Enables change only by writes taken while unlocked
// - Enable bits include video ports 6, 5
//
// Behaviour in brief
// Enable writes are posted: taken on one edge, applied on the next.
// A read right behind a write is answered from the posted value,
// so a read-back always shows what the outputs are about to take.
// This stands in for the read stall; the bus itself never waits.
// Every enable write relocks, accepted or dropped alike, so one
// stray write can never leave the register open for a second.
// Only the whole 32-bit key unlocks; any other value is ignored.
// Lock set and lock clear sit at different addresses: no collision.
// Reserved enable bits and reserved strap bits read zero.
// Writes to the strap word and to unmapped addresses are ignored.
// Read data stand one cycle only and are zero at all other times.
//
// Strap capture
// Pins pass two flops while reset is held, then are captured once,
// on the first edge after release; later changes wait for a reset.
// Hold reset at least two edges so the synchroniser is full.
// A strap read in the first cycle after release sees the default.
//
// Limits
// Software keeps the settle time after enabling a unit, and keeps
// off units that are disabled; neither is enforced by this block.
`timescale 1ns/10ps
`default_nettype none
module pcl_cfg_lock (
   input  wire  logic        mclk,
   input  wire  logic        srst,
   // Register port
   input  wire  logic [31:0] reg_addr,
   input  wire  logic [31:0] reg_wdata,
   input  wire  logic        reg_wr,
   input  wire  logic        reg_rd,
   output logic        [31:0] reg_rdata,
   // Strap pins, asynchronous to mclk
   input  wire  logic        net_mac_enable_pin,
   input  wire  logic        host_port_width_pin,
   input  wire  logic        cpu_clk_mult_hi_pin,
   input  wire  logic        cpu_clk_mult_lo_pin,
   input  wire  logic        byte_order_pin,
   input  wire  logic        boot_select_hi_pin,
   input  wire  logic        boot_select_lo_pin,
   input  wire  logic        extmem_clk_src_hi_pin,
   input  wire  logic        extmem_clk_src_lo_pin,
   // Peripheral enables
   output logic              video_port2_enable,
   output logic              video_port1_enable,
   output logic              two_wire_ctrl_enable,
   output logic              unused_serial1_enable,
   output logic              buffered_serial_enable,
   output logic              audio_serial_enable,
   // Lock state and strap capture done
   output logic              lock_status,
   output logic              strap_valid
);
   import pcl_pkg::*;

   // All state of the block
   typedef struct packed {
      pcl_wr_state_t wstate;    // Posted write pending or not
      logic [31:0]   pend_data; // Masked value waiting to be applied
      logic [31:0]   cfg;       // Applied enable register
      logic          lock;      // Lock status
      logic [31:0]   rdata;     // Read data for the cycle after a read
   } pcl_state_t;

   pcl_state_t  st;          // Current state
   pcl_state_t  next_st;     // Next state
   logic [31:0] strap_word;  // Latched strap status word
   logic [31:0] cfg_view;    // Enable register as software sees it

   // Full-word address match
   // Aliases are not decoded; partial matches read zero
   function automatic logic pcl_hit(input logic [31:0] addr, input logic [31:0] off);
      return addr == off;
   endfunction

   // Decoded strobes
   // The master never raises both strobes in one cycle
   logic wr_cfg;   // Write to the enable register
   logic wr_lock;  // Write to the lock register
   logic rd_cfg;   // Read of the enable register
   logic rd_stat;  // Read of the strap status
   logic rd_lock;  // Read of the lock register

   assign wr_cfg  = reg_wr && pcl_hit(reg_addr, PCL_ADDR_PERIPH_CFG);
   assign wr_lock = reg_wr && pcl_hit(reg_addr, PCL_ADDR_LOCK_KEY);
   assign rd_cfg  = reg_rd && pcl_hit(reg_addr, PCL_ADDR_PERIPH_CFG);
   assign rd_stat = reg_rd && pcl_hit(reg_addr, PCL_ADDR_STRAP_STAT);
   assign rd_lock = reg_rd && pcl_hit(reg_addr, PCL_ADDR_LOCK_KEY);

   // Strap synchroniser and reset-time latch
   // Straps reach the status word only through this latch
   pcl_strap_latch u_strap (
      .mclk        (mclk),
      .srst        (srst),
      .strap_pins  ({net_mac_enable_pin, host_port_width_pin,
                     cpu_clk_mult_hi_pin, cpu_clk_mult_lo_pin, byte_order_pin,
                     boot_select_hi_pin, boot_select_lo_pin,
                     extmem_clk_src_hi_pin, extmem_clk_src_lo_pin}),
      .strap_word  (strap_word),
      .strap_valid (strap_valid)
   );

   // A posted value is forwarded so a read right behind the write sees it
   always_comb begin
      // Pending value wins while it waits to land
      unique case (st.wstate)
         PCL_IDLE: cfg_view = st.cfg;
         PCL_PEND: cfg_view = st.pend_data;
      endcase
   end

   // Next-state logic for lock, enable register and read data
   always_comb begin
      next_st = st;
      // Posted write lands one edge after it was taken
      unique case (st.wstate)
         PCL_IDLE: begin
            // Nothing waiting to land
            next_st.wstate = PCL_IDLE;
         end
         PCL_PEND: begin
            // Apply the posted value now
            next_st.cfg    = st.pend_data;
            next_st.wstate = PCL_IDLE;
         end
      endcase
      // Lock register write: only the exact key unlocks
      if (wr_lock) begin
         if (reg_wdata == PCL_UNLOCK_KEY) begin
            // Full key matched
            next_st.lock = 1'b0;
         end else begin
            // Any other value: lock kept as it was
            next_st.lock = st.lock;
         end
      end
      // Enable register write: accepted only while unlocked, always relocks
      if (wr_cfg) begin
         if (!st.lock) begin
            // Unlocked: post the masked value
            next_st.pend_data = reg_wdata & PCL_CFG_WR_MASK;
            next_st.wstate    = PCL_PEND;
         end
         // Accepted or dropped, the write closes the lock
         next_st.lock = 1'b1;
      end
      // Read data stand only in the cycle after the read strobe
      if (rd_cfg) begin
         // Enable register, posted value forwarded
         next_st.rdata = cfg_view;
      end else if (rd_stat) begin
         // Strap word, reserved bits forced low
         next_st.rdata = strap_word & PCL_STAT_MASK;
      end else if (rd_lock) begin
         // Lock status in bit 0 only
         next_st.rdata = {31'h0000_0000, st.lock};
      end else begin
         // No read or unmapped: bus reads zero
         next_st.rdata = 32'h0000_0000;
      end
      // Synchronous reset: locked, enable defaults, no pending write
      if (srst) begin
         // A pending write is lost with the reset
         next_st.wstate    = PCL_IDLE;
         next_st.pend_data = 32'h0000_0000;
         next_st.cfg       = PCL_CFG_RESET;
         next_st.lock      = PCL_LOCK_RESET;
         next_st.rdata     = 32'h0000_0000;
      end
   end

   // State register
   // Runs every edge; reset is a branch of the next-state logic
   always_ff @(posedge mclk) begin
      st <= next_st;
   end

   // Outputs straight from flops
   // Enables follow the applied register, never the posted value
   assign reg_rdata              = st.rdata;
   assign lock_status            = st.lock;
   assign video_port2_enable     = st.cfg[PCL_VP2_EN_BIT];
   assign video_port1_enable     = st.cfg[PCL_VP1_EN_BIT];
   assign two_wire_ctrl_enable   = st.cfg[PCL_TWI_EN_BIT];
   assign unused_serial1_enable  = st.cfg[PCL_SER1_EN_BIT];
   assign buffered_serial_enable = st.cfg[PCL_SER0_EN_BIT];
   assign audio_serial_enable    = st.cfg[PCL_AUD_EN_BIT];

   // Checks on the block's own behaviour
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   // Lock comes out of reset set
   // Checked while reset is high, so reset does not disable it
   a_lock_after_reset: assert property (@(posedge mclk) disable iff (1'b0)
      srst |=> lock_status)
      else $error("lock not set after reset");

   // Exact key clears the lock
   // Takes effect on the edge after the key write
   a_key_unlocks: assert property (
      wr_lock && reg_wdata == PCL_UNLOCK_KEY |=> !lock_status)
      else $error("key write did not unlock");

   // Wrong key leaves lock unchanged
   // Holds for a locked and an already open register alike
   a_bad_key_hold: assert property (
      wr_lock && reg_wdata != PCL_UNLOCK_KEY |=> lock_status == $past(lock_status))
      else $error("wrong key changed lock");

   // Lock only clears after a full key write
   // Catches a clear from any other address or data
   a_clear_needs_key: assert property (
      $fell(lock_status) |-> $past(wr_lock && reg_wdata == PCL_UNLOCK_KEY))
      else $error("lock cleared without key");

   // Lock only moves on a key or enable write
   // Nothing else on the bus may touch it
   a_lock_write_only: assert property (
      $changed(lock_status) |-> $past(wr_lock || wr_cfg))
      else $error("lock moved without a write");

   // Enable register write relocks
   // Also when the write itself was dropped
   a_cfg_write_relock: assert property (
      wr_cfg |=> lock_status)
      else $error("enable write did not relock");

   // Locked write leaves enables unchanged for two cycles
   // Two cycles, so a late posted apply is caught as well
   a_locked_no_change: assert property (
      wr_cfg && lock_status && st.wstate == PCL_IDLE |=> $stable(st.cfg) ##1 $stable(st.cfg))
      else $error("locked write altered enables");

   // Unlocked write lands two edges later with masked data
   // One edge to post, one edge to apply
   a_unlocked_apply: assert property (
      wr_cfg && !lock_status |-> ##2 st.cfg == ($past(reg_wdata, 2) & PCL_CFG_WR_MASK))
      else $error("unlocked write not applied");

   // A posted value only comes from an unlocked write
   // Keeps a locked write from slipping in through the post stage
   a_post_needs_unlock: assert property (
      st.wstate == PCL_PEND |-> $past(wr_cfg && !lock_status))
      else $error("posted write while locked");

   // A posted value is applied on the very next edge
   // Bounds the read-after-write stall to one cycle
   a_post_applies: assert property (
      st.wstate == PCL_PEND |=> st.cfg == $past(st.pend_data))
      else $error("posted write not applied");

   // Enables change only through the post stage
   // Reset is the one other way in, and it disables this check
   a_cfg_via_post: assert property (
      $changed(st.cfg) |-> $past(st.wstate == PCL_PEND))
      else $error("enables changed without a write");

   // Reserved enable bits hold zero
   // Write mask and reset value must agree on this
   a_cfg_reserved_zero: assert property (
      (st.cfg & ~PCL_CFG_WR_MASK) == 32'h0000_0000)
      else $error("reserved enable bit set");

   // Read right behind a write sees the written value
   // The forward path stands in for the stall
   a_read_after_write: assert property (
      wr_cfg && !lock_status ##1 rd_cfg |=>
      reg_rdata == ($past(reg_wdata, 2) & PCL_CFG_WR_MASK))
      else $error("read after write returned stale data");

   // Lock read shows status bit with upper bits zero
   // Value is the lock as it stood at the read edge
   a_lock_read_fmt: assert property (
      rd_lock |=> reg_rdata[31:1] == 31'h0000_0000 && reg_rdata[0] == $past(lock_status))
      else $error("lock read format wrong");

   // Enable register read ignores lock state
   // Checked with no write pending; the forward case is above
   a_cfg_read_value: assert property (
      rd_cfg && st.wstate == PCL_IDLE |=> reg_rdata == $past(st.cfg))
      else $error("enable read wrong");

   // Strap status reserved bits read zero
   // Whatever the pins showed at capture
   a_stat_reserved: assert property (
      rd_stat |=> reg_rdata[31:12] == 20'h0_0000 && reg_rdata[9:7] == 3'h0)
      else $error("strap reserved bits not zero");

   // Captured straps stay captured until the next reset
   // Pin changes after capture must not reach software
   a_strap_valid_hold: assert property (
      strap_valid |=> strap_valid)
      else $error("strap capture lost");

   // Read data zero outside the answer cycle
   // Lets read data of several blocks be merged by OR
   a_rdata_quiet: assert property (
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside answer cycle");

   // Unmapped reads answer zero
   // Only the three full addresses decode
   a_unmapped_read_zero: assert property (
      reg_rd && !rd_cfg && !rd_stat && !rd_lock |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   // Main scenarios
   c_unlock_and_enable: cover property (
      wr_lock && reg_wdata == PCL_UNLOCK_KEY ##1 wr_cfg ##1 rd_cfg);
   c_locked_write: cover property (wr_cfg && lock_status);
   c_strap_read: cover property (strap_valid && rd_stat);
   c_bad_key: cover property (wr_lock && reg_wdata != PCL_UNLOCK_KEY);
   c_unmapped_read: cover property (reg_rd && !rd_cfg && !rd_stat && !rd_lock);

endmodule
`default_nettype wire

// ===== verilog/pcl_pkg.sv
// Package for the peripheral configuration lock and device strap status block.
// Assumes one 125 MHz clock domain and a plain strobe register port.
package pcl_pkg;

   // Register byte addresses
   localparam logic [31:0] PCL_ADDR_PERIPH_CFG = 32'h01b3_f000;  // Guarded enable register
   localparam logic [31:0] PCL_ADDR_STRAP_STAT = 32'h01b3_f004;  // Read-only strap word
   localparam logic [31:0] PCL_ADDR_LOCK_KEY   = 32'h01b3_f018;  // Key write, lock read

   // Unlock key and lock reset value
   localparam logic [31:0] PCL_UNLOCK_KEY      = 32'h10c0_010c;
   localparam logic        PCL_LOCK_RESET      = 1'b1;

   // CPU cycles software waits after enabling a unit before touching it
   localparam int PCL_SETTLE_CYCLES = 128;

   // Enable register field positions
   localparam int PCL_VP2_EN_BIT   = 6;
   localparam int PCL_VP1_EN_BIT   = 5;
   localparam int PCL_TWI_EN_BIT   = 3;
   localparam int PCL_SER1_EN_BIT  = 2;
   localparam int PCL_SER0_EN_BIT  = 1;
   localparam int PCL_AUD_EN_BIT   = 0;

   // Enable register writable bits and reset value
   localparam logic [31:0] PCL_CFG_WR_MASK     = 32'h0000_006f;
   localparam logic [31:0] PCL_CFG_RESET       = 32'h0000_0006;

   // Strap status field positions
   localparam int PCL_NET_MAC_ENABLE_STATUS_BIT   = 11;
   localparam int PCL_HP_WIDTH_BIT = 10;
   localparam int PCL_CLK_MULT_HI  = 6;
   localparam int PCL_CLK_MULT_LO  = 5;
   localparam int PCL_BYTE_ORD_BIT = 4;
   localparam int PCL_BOOT_HI      = 3;
   localparam int PCL_BOOT_LO      = 2;
   localparam int PCL_EXCLK_HI     = 1;
   localparam int PCL_EXCLK_LO     = 0;

   // Strap status implemented bits and reset value (little-endian default)
   localparam logic [31:0] PCL_STAT_MASK       = 32'h0000_0c7f;
   localparam logic [31:0] PCL_STAT_RESET      = 32'h0000_0010;

   // Posted-write stage of the enable register
   typedef enum logic {
      PCL_IDLE = 1'b0,
      PCL_PEND = 1'b1
   } pcl_wr_state_t;

endpackage

// ===== verilog/pcl_strap_latch.sv
// Strap capture: synchronises the strap pins and latches them once after reset.
// Assumes pins are steady while srst is high and for two edges after its release.
`timescale 1ns/10ps
`default_nettype none
module pcl_strap_latch (
   input  wire  logic        mclk,
   input  wire  logic        srst,
   input  wire  logic [8:0]  strap_pins,
   output logic        [31:0] strap_word,
   output logic              strap_valid
);
   import pcl_pkg::*;

   // All state of the latch
   typedef struct packed {
      logic [8:0]  sync1;   // First synchroniser stage
      logic [8:0]  sync2;   // Second synchroniser stage
      logic [31:0] word;    // Latched strap word
      logic        valid;   // Capture done
   } pcl_strap_st_t;

   pcl_strap_st_t st;
   pcl_strap_st_t next_st;

   // Maps the synchronised pins into the status word layout
   function automatic logic [31:0] pcl_place(input logic [8:0] p);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[PCL_NET_MAC_ENABLE_STATUS_BIT]   = p[8];
      w[PCL_HP_WIDTH_BIT] = p[7];
      w[PCL_CLK_MULT_HI]  = p[6];
      w[PCL_CLK_MULT_LO]  = p[5];
      w[PCL_BYTE_ORD_BIT] = p[4];
      w[PCL_BOOT_HI]      = p[3];
      w[PCL_BOOT_LO]      = p[2];
      w[PCL_EXCLK_HI]     = p[1];
      w[PCL_EXCLK_LO]     = p[0];
      return w & PCL_STAT_MASK;
   endfunction

   // Next state: synchroniser always runs, capture happens once after reset
   always_comb begin
      next_st       = st;
      next_st.sync1 = strap_pins;
      next_st.sync2 = st.sync1;
      if (srst) begin
         next_st.word  = PCL_STAT_RESET;
         next_st.valid = 1'b0;
      end else if (!st.valid) begin
         // Latched once; later pin changes are ignored
         next_st.word  = pcl_place(st.sync2);
         next_st.valid = 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      st <= next_st;
   end

   assign strap_word  = st.word;
   assign strap_valid = st.valid;

   // Latched word never moves once valid
   a_strap_frozen: assert property (@(posedge mclk) disable iff (srst)
      st.valid && $past(st.valid) |-> $stable(st.word))
      else $error("strap word changed after capture");

endmodule
`default_nettype wire

// ===== verif/pcl_cfg_lock_tb.sv
// Self-checking bench for the enable register lock and strap status block.
// Assumes package pcl_pkg and one 125 MHz clock; the bench drives every port.
`timescale 1ns/10ps
`default_nettype none
module pcl_cfg_lock_tb;
   import pcl_pkg::*;
   logic        mclk;             // Bench clock
   logic        srst;             // Synchronous reset
   logic        reg_wr;           // Write strobe
   logic        reg_rd;           // Read strobe
   logic [31:0] reg_addr;         // Register address
   logic [31:0] reg_wdata;        // Write data
   logic [31:0] reg_rdata;        // Read data, cycle after the strobe
   logic [8:0]  pins;             // Strap pins, mac enable down to clock source lo
   logic [8:0]  sp;               // Strap pattern for one reset
   logic [31:0] cv;               // Random enable value
   logic [5:0]  en;               // Enable outputs, video port 2 down to audio
   logic        lock_status;      // Lock flag from the design
   logic        strap_valid;      // Strap capture done
   logic [31:0] exp_q[$];         // Expected read data, oldest first
   logic        rd_seen;          // A read was taken at the last edge
   int          fail_count;       // Mismatches
   int          samples_checked;  // Comparisons made
   integer      seed;             // Random seed

   pcl_cfg_lock dut_u (
      .mclk                   (mclk),
      .srst                   (srst),
      .reg_addr               (reg_addr),
      .reg_wdata              (reg_wdata),
      .reg_wr                 (reg_wr),
      .reg_rd                 (reg_rd),
      .reg_rdata              (reg_rdata),
      .net_mac_enable_pin     (pins[8]),
      .host_port_width_pin    (pins[7]),
      .cpu_clk_mult_hi_pin    (pins[6]),
      .cpu_clk_mult_lo_pin    (pins[5]),
      .byte_order_pin         (pins[4]),
      .boot_select_hi_pin     (pins[3]),
      .boot_select_lo_pin     (pins[2]),
      .extmem_clk_src_hi_pin  (pins[1]),
      .extmem_clk_src_lo_pin  (pins[0]),
      .video_port2_enable     (en[5]),
      .video_port1_enable     (en[4]),
      .two_wire_ctrl_enable   (en[3]),
      .unused_serial1_enable  (en[2]),
      .buffered_serial_enable (en[1]),
      .audio_serial_enable    (en[0]),
      .lock_status            (lock_status),
      .strap_valid            (strap_valid)
   );

   // Free-running 8 ns clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Prints the counts and the verdict, then stops
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Compares one value and counts it
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask

   // One bus cycle; strobes are rewritten every cycle so none lingers
   task automatic bus(input logic w, input logic r, input logic [31:0] a,
                      input logic [31:0] d);
      reg_wr    <= w;
      reg_rd    <= r;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
   endtask

   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask

   // Read whose expected data is queued for the monitor
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, 1'b1, a, 32'h0000_0000);
   endtask

   // Level outputs, looked at once the edge's updates have landed
   task automatic levels(input logic [31:0] c, input logic lk);
      #1;
      check("enables", {26'h000_0000, c[6:5], c[3:0]}, {26'h000_0000, en});
      check("lock_status", {31'h0000_0000, lk}, {31'h0000_0000, lock_status});
      check("strap_valid", 32'h0000_0001, {31'h0000_0000, strap_valid});
      @(posedge mclk);
   endtask

   // Resets with a strap pattern held through capture
   task automatic do_reset(input logic [8:0] p);
      srst <= 1'b1;
      pins <= p;
      idle(4);
      srst <= 1'b0;
      idle(2);
   endtask

   // Strap word expected for a pin pattern; reserved bits zero
   function automatic logic [31:0] sx(input logic [8:0] p);
      return {20'h0_0000, p[8:7], 3'b000, p[6:0]};
   endfunction

   // Monitor: read data stand in the cycle after the taken strobe
   always @(posedge mclk) begin
      if (rd_seen) begin
         if (exp_q.size() == 0)
            check("read_count", 32'h0000_0000, 32'h0000_0001);
         else
            check("read_data", exp_q.pop_front(), reg_rdata);
      end
      rd_seen = reg_rd;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      check("run_time", 32'h0000_0000, 32'h0000_0001);
      give_verdict();
   end

   // Main sequence; the bench reaches no peripheral, so none is touched while off
   // and no shared pin function is switched under a running unit
   initial begin
      seed = 1;
      fail_count = 0;
      samples_checked = 0;
      rd_seen = 1'b0;
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 32'h0000_0000;
      reg_wdata = 32'h0000_0000;
      pins = 9'h010;
      // Every strap code of each two-bit field, other pins random
      for (int i = 0; i < 4; i++) begin
         sp = 9'($random(seed));
         sp[6:5] = i[1:0];
         sp[3:2] = i[1:0];
         sp[1:0] = i[1:0];
         do_reset(sp);
         levels(PCL_CFG_RESET, 1'b1);
         rd(PCL_ADDR_STRAP_STAT, sx(sp));
         pins <= ~sp;
         wr(PCL_ADDR_STRAP_STAT, 32'hffff_ffff);
         idle(4);
         rd(PCL_ADDR_STRAP_STAT, sx(sp));
      end
      // Locked enable write is dropped
      rd(PCL_ADDR_LOCK_KEY, 32'h0000_0001);
      wr(PCL_ADDR_PERIPH_CFG, 32'h0000_0060);
      idle(1);
      rd(PCL_ADDR_PERIPH_CFG, PCL_CFG_RESET);
      // Keys off by one bit, then a random one
      for (int k = 0; k < 33; k++) begin
         wr(PCL_ADDR_LOCK_KEY, (k < 32) ? (PCL_UNLOCK_KEY ^ (32'h1 << k)) : $random(seed));
         rd(PCL_ADDR_LOCK_KEY, 32'h0000_0001);
      end
      // Unmapped place ignores writes and reads zero
      wr(32'h01b3_f008, PCL_UNLOCK_KEY);
      rd(32'h01b3_f008, 32'h0000_0000);
      rd(PCL_ADDR_LOCK_KEY, 32'h0000_0001);
      // Unlock, write all ones, read straight behind the write
      wr(PCL_ADDR_LOCK_KEY, PCL_UNLOCK_KEY);
      rd(PCL_ADDR_LOCK_KEY, 32'h0000_0000);
      wr(PCL_ADDR_PERIPH_CFG, 32'hffff_ffff);
      rd(PCL_ADDR_PERIPH_CFG, PCL_CFG_WR_MASK);
      rd(PCL_ADDR_LOCK_KEY, 32'h0000_0001);
      idle(PCL_SETTLE_CYCLES);
      levels(PCL_CFG_WR_MASK, 1'b1);
      // Second write without a fresh key is dropped
      wr(PCL_ADDR_PERIPH_CFG, 32'h0000_0000);
      idle(1);
      rd(PCL_ADDR_PERIPH_CFG, PCL_CFG_WR_MASK);
      // Random enable values, back to back key, write and read
      for (int k = 0; k < 8; k++) begin
         cv = $random(seed);
         wr(PCL_ADDR_LOCK_KEY, PCL_UNLOCK_KEY);
         wr(PCL_ADDR_PERIPH_CFG, cv);
         rd(PCL_ADDR_PERIPH_CFG, cv & PCL_CFG_WR_MASK);
      end
      idle(1);
      levels(cv & PCL_CFG_WR_MASK, 1'b1);
      // Reset in mid-run while unlocked
      wr(PCL_ADDR_LOCK_KEY, PCL_UNLOCK_KEY);
      do_reset(9'h010);
      rd(PCL_ADDR_LOCK_KEY, 32'h0000_0001);
      rd(PCL_ADDR_PERIPH_CFG, PCL_CFG_RESET);
      rd(PCL_ADDR_STRAP_STAT, PCL_STAT_RESET);
      idle(2);
      if (exp_q.size() != 0)
         check("reads_left", 32'h0000_0000, 32'h0000_0001);
      give_verdict();
   end
endmodule
`default_nettype wire
